// *** core/fdcc_ctrl.sv ***
/*
 * fdcc_ctrl: controller outside a chain of FIFO devices, both daisy chain and series
 * (passthrough) chain. Writes words into the chain head, reads the tail, composes
 * chain flags and times the ripple latencies. Software reaches it over Avalon-MM.
 * Assumes chain pins are asynchronous to clk; write, read and transfer clocks of
 * the chain are generated outside at the periods given in fdcc_pkg.
 */
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
// What the document requires
// R1: first device of a daisy chain gets first_device_select held low.
// R2: every other daisy-chain device gets first_device_select held high.
// R3: each write_token_out feeds next write_token_in, ring closing to first.
// R4: each read_token_out feeds next read_token_in.
// R5: all offset_load inputs driven from one common signal.
// R6: half_level_flag is not meaningful in daisy chain; it is ignored.
// R7: chain flags are OR of every device flag; near flags approximate.
// R8: device registers empty/full once, near flags asynchronous, in daisy chain.
// R9: series chain needs no glue; capacity is sum of device depths.
// R10: passthrough mode is selected on every device during master reset.
// R11: read clock of every series-chain device runs continuously.
// R12: a valid word drives that device's output ready low.
// R13: tail output ready low within (N-1)*4 transfer plus 3 read clocks.
// R14: ripple latency only applies to the first word into an empty chain.
// R15: a freed slot moves upstream; each gaining device drives input ready low.
// R16: head input ready low within (N-1)*3 transfer plus 2 write clocks; drain watchdog uses the R13 budget.
// R17: transfer clock tied to the faster of write and read clock.
// R18: extra cycles allowed in budget when clock skew is not met.
// R19: passthrough strap pattern (0,0,1) or (1,0,1) during reset.
// R20: write_token_out marks writing a device's last location.
// R21: read_token_out marks reading a device's last location.
// R22: upstream output ready drives downstream write enable, and back, on transfer clock.
`timescale 1ns/10ps
module fdcc_ctrl #(
  parameter int N_DEV = 3,
  parameter int WIDTH = 18,
  parameter int RBUF  = 4
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  // avalon-mm slave
  input  wire logic [5:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // chain head (write side)
  output logic      [WIDTH-1:0]       chain_wdata,
  output logic                        chain_write_n,
  input  wire logic                   head_input_ready_flag_n,
  // chain tail (read side)
  input  wire logic [WIDTH-1:0]       chain_rdata,
  output logic                        chain_read_n,
  input  wire logic                   tail_output_ready_n,
  // chain control
  output logic                        chain_reset_n,
  output logic                        offset_load_n,
  output fdcc_pkg::fdcc_strap_t       strap [N_DEV],
  input  wire fdcc_pkg::fdcc_flags_t  dev_flags [N_DEV]
);

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [1:0]        ir_sync, or_sync;
  logic [WIDTH-1:0]  rd_s1, rd_s2;
  fdcc_pkg::fdcc_flags_t fl_s1 [N_DEV];
  fdcc_pkg::fdcc_flags_t fl_s2 [N_DEV];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ir_sync <= 2'h3;
      or_sync <= 2'h3;
      rd_s1   <= '0;
      rd_s2   <= '0;
      for (int i = 0; i < N_DEV; i++) begin
        fl_s1[i] <= '0;
        fl_s2[i] <= '0;
      end
    end else if (ce) begin
      ir_sync <= {ir_sync[0], head_input_ready_flag_n};
      or_sync <= {or_sync[0], tail_output_ready_n}; // R11
      rd_s1   <= chain_rdata;
      rd_s2   <= rd_s1;
      for (int i = 0; i < N_DEV; i++) begin
        fl_s1[i] <= dev_flags[i];
        fl_s2[i] <= fl_s1[i];
      end
    end
  end

  wire head_ready = !ir_sync[1];
  wire tail_valid = !or_sync[1];

  // ***************************************************************
  // composite flags
  // ***************************************************************
  function automatic fdcc_pkg::fdcc_flags_t or_flags(input fdcc_pkg::fdcc_flags_t f [N_DEV]);
    fdcc_pkg::fdcc_flags_t acc;
    acc = '0;
    for (int i = 0; i < N_DEV; i++) begin
      acc = acc | f[i];
    end
    return acc;
  endfunction : or_flags

  wire fdcc_pkg::fdcc_flags_t chain_flags = or_flags(fl_s2); // R7 R6 R8

  // ***************************************************************
  // control register and straps
  // ***************************************************************
  logic [31:0] ctrl;
  logic [31:0] timeout;
  wire         pass_mode = ctrl[fdcc_pkg::CTRL_MODE_BIT];
  wire         in_reset  = ctrl[fdcc_pkg::CTRL_RESET_BIT];

  assign chain_reset_n = !in_reset;
  assign offset_load_n = !ctrl[fdcc_pkg::CTRL_LOAD_BIT]; // R5

  always_comb begin
    for (int i = 0; i < N_DEV; i++) begin
      if (pass_mode) begin
        strap[i].first_device_select = ctrl[fdcc_pkg::CTRL_FIRSTSEL_BIT]; // R10 R19
        strap[i].read_token_in       = 1'b0;
        strap[i].write_token_in      = 1'b1;
      end else begin
        strap[i].first_device_select = (i != 0); // R1 R2
        strap[i].read_token_in       = 1'b1;     // ring tokens R3 R4 wired outside
        strap[i].write_token_in      = 1'b1;
      end
    end
  end

  // ***************************************************************
  // write path to chain head
  // ***************************************************************
  logic             wpend;
  logic [1:0]       wr_gap;

  wire bus_wr = ce && avs_write && !avs_waitrequest;
  wire bus_rd = ce && avs_read  && !avs_waitrequest;
  // head ready is seen two stages late: hold off until it reflects the last word
  wire do_wr  = wpend && head_ready && !in_reset && wr_gap == 2'h0; // R22

  assign chain_write_n = !do_wr;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wpend       <= 1'b0;
      chain_wdata <= '0;
      wr_gap      <= '0;
    end else if (ce) begin
      if (do_wr) begin
        wr_gap <= 2'h2;
      end else if (wr_gap != 2'h0) begin
        wr_gap <= wr_gap - 2'h1;
      end
      if (bus_wr && avs_address[3:0] == fdcc_pkg::REG_WDATA) begin
        wpend       <= 1'b1;
        chain_wdata <= avs_writedata[WIDTH-1:0];
      end else if (do_wr) begin
        wpend <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // read path from chain tail into local buffer
  // ***************************************************************
  localparam int AW = $clog2(RBUF);
  logic [AW:0]      rb_wp, rb_rp;
  logic [WIDTH-1:0] rb_q;
  logic [1:0]       rd_gap;
  wire rb_full  = (rb_wp[AW] != rb_rp[AW]) && (rb_wp[AW-1:0] == rb_rp[AW-1:0]);
  wire rb_empty = (rb_wp == rb_rp);
  // tail flag and word arrive two stages late: wait until they show the state after the last read
  wire take     = tail_valid && !rb_full && !in_reset && chain_read_n && rd_gap == 2'h0; // R12
  wire pop      = bus_rd && avs_address[3:0] == fdcc_pkg::REG_RDATA && !rb_empty;

  fdcc_word_mem #(.WIDTH(WIDTH), .DEPTH(RBUF)) u_rbuf (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (take),
    .wr_addr (rb_wp[AW-1:0]),
    .wr_data (rd_s2),
    .rd_addr (rb_rp[AW-1:0]),
    .rd_data (rb_q)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chain_read_n <= 1'b1;
      rb_wp        <= '0;
      rb_rp        <= '0;
      rd_gap       <= '0;
    end else if (ce) begin
      chain_read_n <= !take;
      if (take) begin
        rd_gap <= 2'h3;
      end else if (rd_gap != 2'h0) begin
        rd_gap <= rd_gap - 2'h1;
      end
      if (take) rb_wp <= rb_wp + 1'b1;
      if (pop)  rb_rp <= rb_rp + 1'b1;
    end
  end

  // ***************************************************************
  // ripple latency watchdogs
  // ***************************************************************
  logic [31:0] fill_cnt, drain_cnt, last_lat;
  logic        fill_run, drain_run, late_or, late_ir;
  logic        was_empty;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fill_cnt  <= '0;
      drain_cnt <= '0;
      fill_run  <= 1'b0;
      drain_run <= 1'b0;
      late_or   <= 1'b0;
      late_ir   <= 1'b0;
      last_lat  <= '0;
      was_empty <= 1'b1;
    end else if (ce) begin
      if (do_wr && was_empty && !tail_valid) begin // R14
        fill_run <= 1'b1;
        fill_cnt <= '0;
      end else if (fill_run && tail_valid) begin
        fill_run <= 1'b0;
        last_lat <= fill_cnt;
      end else if (fill_run) begin
        fill_cnt <= fill_cnt + 32'h1;
        if (fill_cnt == timeout) late_or <= 1'b1; // R13 R18
      end
      was_empty <= chain_flags.empty || tail_valid ? !tail_valid : was_empty;
      if (take && !head_ready) begin // R15
        drain_run <= 1'b1;
        drain_cnt <= '0;
      end else if (drain_run && head_ready) begin
        drain_run <= 1'b0;
      end else if (drain_run) begin
        drain_cnt <= drain_cnt + 32'h1;
        if (drain_cnt == timeout) late_ir <= 1'b1; // R16 R18
      end
      if (bus_wr && avs_address[3:0] == fdcc_pkg::REG_STATUS) begin
        late_or <= (fill_run && fill_cnt == timeout) ? 1'b1 : late_or & ~avs_writedata[fdcc_pkg::ST_LATE_OR_BIT];
        late_ir <= (drain_run && drain_cnt == timeout) ? 1'b1 : late_ir & ~avs_writedata[fdcc_pkg::ST_LATE_IR_BIT];
      end
    end
  end

  // default budget: (N-1)*4 xfer + 3 rclk, and slack for skew
  localparam int BUDGET_NS = (N_DEV - 1) * fdcc_pkg::FILL_XFER_PER_DEV * fdcc_pkg::XFER_PERIOD_NS // R17
                           + fdcc_pkg::FILL_RCLK_TAIL * fdcc_pkg::RCLK_PERIOD_NS;
  localparam logic [31:0] BUDGET_CYC = 32'((BUDGET_NS * 1000) / fdcc_pkg::CLK_PERIOD_PS
                                       + fdcc_pkg::SKEW_SLACK_CYCLES + 4);

  // ***************************************************************
  // avalon slave: one wait state on reads, zero on writes
  // ***************************************************************
  logic rd_wait;
  assign avs_waitrequest = avs_read && !rd_wait;

  wire [7:0] status = {wpend, late_ir, late_or, !rb_empty, chain_flags.near_full,
                       chain_flags.near_empty, chain_flags.full, chain_flags.empty};

  wire [3:0]  ra = avs_address[3:0];
  wire [31:0] rsel = (ra == fdcc_pkg::REG_CTRL)    ? ctrl :
                     (ra == fdcc_pkg::REG_STATUS)  ? {24'h0, status} :
                     (ra == fdcc_pkg::REG_RDATA)   ? 32'(rb_q) :
                     (ra == fdcc_pkg::REG_TIMEOUT) ? timeout :
                     (ra == fdcc_pkg::REG_LATENCY) ? last_lat :
                     (ra == fdcc_pkg::REG_ID)      ? fdcc_pkg::ID_VALUE : 32'h0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_wait      <= 1'b0;
      avs_readdata <= '0;
      ctrl         <= fdcc_pkg::CTRL_RESET_VALUE;
      timeout      <= '0;
    end else if (ce) begin
      rd_wait      <= avs_read && !rd_wait;
      if (avs_read && !rd_wait) avs_readdata <= rsel;
      if (bus_wr && ra == fdcc_pkg::REG_CTRL)    ctrl    <= avs_writedata;
      if (bus_wr && ra == fdcc_pkg::REG_TIMEOUT) timeout <= avs_writedata;
      if (timeout == 32'h0) timeout <= BUDGET_CYC;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_write_gated: assert property (@(posedge clk) disable iff (reset) // R22
    !chain_write_n |-> head_ready && wpend ##1 chain_write_n [*2]) else $error("write issued without head ready");
  chk_read_gated: assert property (@(posedge clk) disable iff (reset) // R12
    ce && take |=> !chain_read_n && !take ##1 !take [*2]) else $error("read not issued after valid word");
  chk_daisy_first: assert property (@(posedge clk) disable iff (reset) // R1
    !pass_mode |-> !strap[0].first_device_select) else $error("first device not selected");
  chk_pass_strap: assert property (@(posedge clk) disable iff (reset) // R19
    pass_mode |-> !strap[0].read_token_in && strap[0].write_token_in) else $error("bad passthrough strap");
  chk_load_common: assert property (@(posedge clk) disable iff (reset) // R5
    offset_load_n == !ctrl[fdcc_pkg::CTRL_LOAD_BIT]) else $error("load line mismatch");
  chk_fill_late: assert property (@(posedge clk) disable iff (reset) // R13
    ce && fill_run && fill_cnt == timeout |=> late_or) else $error("late fill not flagged");
  chk_drain_late: assert property (@(posedge clk) disable iff (reset) // R16
    ce && drain_run && drain_cnt == timeout |=> late_ir) else $error("late drain not flagged");
  chk_reset_out: assert property (@(posedge clk) disable iff (reset) // R10
    in_reset |-> chain_write_n && !chain_reset_n) else $error("write during chain reset");

endmodule : fdcc_ctrl

// *** core/fdcc_pkg.sv ***
/*
 * fdcc_pkg: constants and carrier types for the FIFO cascade controller.
 * Assumes a 200 MHz system clock; all chain pins are external and asynchronous.
 */
package fdcc_pkg;

  // ***************************************************************
  // register map (Avalon-MM word addresses, byte address = 4 * index)
  // ***************************************************************
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h1;
  localparam logic [3:0] REG_WDATA     = 4'h2;
  localparam logic [3:0] REG_RDATA     = 4'h3;
  localparam logic [3:0] REG_TIMEOUT   = 4'h4;
  localparam logic [3:0] REG_LATENCY   = 4'h5;
  localparam logic [3:0] REG_ID        = 4'h6;

  // ctrl fields
  localparam int CTRL_MODE_BIT    = 0;   // 1 = passthrough series chain, 0 = daisy chain
  localparam int CTRL_RESET_BIT   = 1;   // holds chain master reset while set
  localparam int CTRL_LOAD_BIT    = 2;   // drives the common offset load line
  localparam int CTRL_FIRSTSEL_BIT = 3;  // pattern select: first_device_select level in passthrough reset
  localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0002;

  // status fields
  localparam int ST_EMPTY_BIT     = 0;
  localparam int ST_FULL_BIT      = 1;
  localparam int ST_NEAR_EMPTY_BIT = 2;
  localparam int ST_NEAR_FULL_BIT = 3;
  localparam int ST_RDVALID_BIT   = 4;
  localparam int ST_LATE_OR_BIT   = 5;
  localparam int ST_LATE_IR_BIT   = 6;
  localparam int ST_BUSY_BIT      = 7;

  // arbitrary identity value
  localparam logic [31:0] ID_VALUE = 32'h00c0_ffee;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_PS       = 5000;
  localparam int XFER_PERIOD_NS      = 10;
  localparam int WCLK_PERIOD_NS      = 10;
  localparam int RCLK_PERIOD_NS      = 10;
  localparam int FILL_XFER_PER_DEV   = 4;
  localparam int FILL_RCLK_TAIL      = 3;
  localparam int DRAIN_XFER_PER_DEV  = 3;
  localparam int DRAIN_WCLK_TAIL     = 2;
  localparam int SKEW_SLACK_CYCLES   = 4;
  localparam int RESET_HOLD_NS       = 50;
  localparam int RESET_HOLD_CYC      = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef enum logic [1:0] {FDCC_DAISY, FDCC_PASS} fdcc_mode_t;

  typedef struct packed {
    logic empty;
    logic full;
    logic near_empty;
    logic near_full;
  } fdcc_flags_t;

  typedef struct packed {
    logic first_device_select;
    logic read_token_in;
    logic write_token_in;
  } fdcc_strap_t;

endpackage : fdcc_pkg

// *** core/fdcc_word_mem.sv ***
/*
 * fdcc_word_mem: small read buffer holding the last words taken from the chain.
 * Assumes one clock; read data come out of a register.
 */
`timescale 1ns/10ps
module fdcc_word_mem #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      store[wr_addr] <= wr_data;
    end
    if (ce) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule : fdcc_word_mem

// *** tb/fdcc_chain_model.sv ***
/* fdcc_chain_model: behavioural series chain of FIFO devices in passthrough mode.
   Assumes one clock stands for the write, read and transfer clocks of every device. */
`timescale 1ns/10ps
module fdcc_chain_model #(
  parameter int N_DEV = 3,
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] chain_wdata,
  input  wire logic             chain_write_n,
  output logic                  head_input_ready_flag_n,
  output logic      [WIDTH-1:0] chain_rdata,
  input  wire logic             chain_read_n,
  output logic                  tail_output_ready_n,
  input  wire logic             chain_reset_n,
  output fdcc_pkg::fdcc_flags_t dev_flags [N_DEV],
  input  wire logic [9:0]       fill_dly,
  input  wire logic [9:0]       drain_dly
);
  localparam int CAP = N_DEV * DEPTH;
  logic [WIDTH-1:0] q [$];
  int               t_q [$];
  int               cyc = 0;
  int               free_at = 0;
  int               fill = 0;
  int               wr_loc = 0;
  int               rd_loc = 0;
  int               wr_owner = 0;
  int               rd_owner = 0;
  initial begin
    head_input_ready_flag_n = 1'b1;
    tail_output_ready_n = 1'b1;
    chain_rdata = '0;
  end
  // no half level flag and no glue between devices
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (chain_reset_n !== 1'b1) begin
      q.delete();
      t_q.delete();
    end else begin
      if (chain_read_n === 1'b0 && tail_output_ready_n === 1'b0) begin
        if (q.size() == CAP)
          free_at = cyc + drain_dly;
        void'(q.pop_front());
        void'(t_q.pop_front());
        rd_loc = (rd_loc + 1) % DEPTH;
        if (rd_loc == 0) rd_owner = (rd_owner + 1) % N_DEV;
      end
      if (chain_write_n === 1'b0 && head_input_ready_flag_n === 1'b0) begin
        t_q.push_back(q.size() == 0 ? cyc + fill_dly : cyc);
        q.push_back(chain_wdata);
        wr_loc = (wr_loc + 1) % DEPTH;
        if (wr_loc == 0) wr_owner = (wr_owner + 1) % N_DEV;
      end
    end
    fill <= q.size();
    head_input_ready_flag_n <= !(q.size() < CAP && cyc >= free_at);
    tail_output_ready_n <= !(q.size() > 0 && cyc >= t_q[0]);
    // released output bus toggles instead of holding the old word
    chain_rdata <= (q.size() > 0 && cyc >= t_q[0]) ? q[0] : ~chain_rdata;
  end
  // words settle at the tail end first
  always_comb begin
    int rem;
    int c;
    c = 0;
    rem = fill;
    for (int i = N_DEV - 1; i >= 0; i--) begin
      c = (rem > DEPTH) ? DEPTH : rem;
      rem = rem - c;
      dev_flags[i] = {c == 0, c == DEPTH, c < 2, c > DEPTH - 2};
    end
  end
endmodule : fdcc_chain_model

// *** tb/fdcc_ctrl_tb_top.sv ***
/* fdcc_ctrl_tb_top: self-checking bench for the cascade controller, Avalon-MM master
   tasks and a queue model of the chain contents. Assumes fdcc_pkg and the design. */
`timescale 1ns/10ps
module fdcc_ctrl_tb_top;
  localparam int ND = 3;
  localparam int W = 18;
  localparam int CAP = ND * 4;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic [5:0]            avs_address = '0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = '0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [W-1:0]          chain_wdata;
  logic [W-1:0]          chain_rdata;
  logic                  chain_write_n;
  logic                  chain_read_n;
  logic                  head_input_ready_flag_n;
  logic                  tail_output_ready_n;
  logic                  chain_reset_n;
  logic                  offset_load_n;
  fdcc_pkg::fdcc_strap_t strap [ND];
  fdcc_pkg::fdcc_flags_t dev_flags [ND];
  logic [9:0]            fill_dly = 10'h004;
  logic [9:0]            drain_dly = 10'h003;
  logic [31:0]           rnd = 32'h0001_26d3;
  logic [W-1:0]          exp_q [$];
  int                    fail_count = 0;
  int                    checked = 0;
  int                    cyc = 0;

  fdcc_ctrl #(.N_DEV(ND), .WIDTH(W), .RBUF(4)) u_fdcc_ctrl (.clk, .reset, .ce(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .chain_wdata, .chain_write_n,
    .head_input_ready_flag_n, .chain_rdata, .chain_read_n, .tail_output_ready_n, .chain_reset_n,
    .offset_load_n, .strap, .dev_flags);
  fdcc_chain_model #(.N_DEV(ND), .WIDTH(W), .DEPTH(4)) u_chain (.clk, .chain_wdata, .chain_write_n,
    .head_input_ready_flag_n, .chain_rdata, .chain_read_n, .tail_output_ready_n, .chain_reset_n,
    .dev_flags, .fill_dly, .drain_dly);

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, expv, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= {2'h0, a};
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= {2'h0, a};
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : rd
  task automatic wait_bit(input int b, input logic v, output bit ok);
    logic [31:0] st;
    ok = 0;
    repeat (150) begin
      rd(fdcc_pkg::REG_STATUS, st);
      if (st[b] === v) begin
        ok = 1;
        break;
      end
    end
  endtask : wait_bit
  task automatic push_word(output bit ok);
    rnd = xs(rnd);
    wr(fdcc_pkg::REG_WDATA, rnd);
    exp_q.push_back(rnd[W-1:0]);
    wait_bit(fdcc_pkg::ST_BUSY_BIT, 1'b0, ok);
  endtask : push_word
  task automatic pop_chk;
    logic [31:0] d;
    bit          ok;
    wait_bit(fdcc_pkg::ST_RDVALID_BIT, 1'b1, ok);
    rd(fdcc_pkg::REG_RDATA, d);
    check("chain word", d, {14'h0, exp_q.pop_front()});
  endtask : pop_chk
  task automatic chk_flags;
    logic [3:0]  e;
    logic [31:0] st;
    e = '0;
    for (int i = 0; i < ND; i++)
      e = e | {dev_flags[i].near_full, dev_flags[i].near_empty, dev_flags[i].full, dev_flags[i].empty};
    rd(fdcc_pkg::REG_STATUS, st);
    check("chain flags", {28'h0, st[3:0]}, {28'h0, e});
  endtask : chk_flags
  task automatic wrap_up;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // ***************************************************************
  // sequence
  // ***************************************************************
  initial begin
    logic [31:0] d;
    bit          ok;
    int          n;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(fdcc_pkg::REG_CTRL, d);
    check("ctrl reset", d, fdcc_pkg::CTRL_RESET_VALUE);
    check("chain reset", chain_reset_n, 1'b0);
    rd(fdcc_pkg::REG_ID, d);
    check("id", d, fdcc_pkg::ID_VALUE);
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, d);
    check("unmapped", d, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(fdcc_pkg::REG_CTRL, {28'h0, k[2], k[1], 1'b1, k[0]});
      @(posedge clk);
      check("load line", offset_load_n, !k[1]);
      for (int i = 0; i < ND; i++)
        if (k[0])
          check("pass strap", {29'h0, strap[i]}, {29'h0, k[2], 2'b01});
        else
          check("daisy select", strap[i].first_device_select, i != 0);
    end
    wr(fdcc_pkg::REG_CTRL, 32'h1);
    @(posedge clk);
    check("chain run", chain_reset_n, 1'b1);
    repeat (3) push_word(ok);
    repeat (3) pop_chk();
    rd(fdcc_pkg::REG_STATUS, d);
    check("late fill fast", d[fdcc_pkg::ST_LATE_OR_BIT], 1'b0);
    drain_dly <= 10'h0c8;
    n = 0;
    ok = 1;
    while (ok && n < 40) begin
      push_word(ok);
      if (ok)
        n++;
    end
    check("capacity", n >= CAP && n <= CAP + 4, 1'b1);
    chk_flags();
    pop_chk();
    wait_bit(fdcc_pkg::ST_LATE_IR_BIT, 1'b1, ok);
    check("late slot", ok, 1'b1);
    wait_bit(fdcc_pkg::ST_BUSY_BIT, 1'b0, ok);
    check("slot refill", ok, 1'b1);
    wr(fdcc_pkg::REG_STATUS, 32'h40);
    rd(fdcc_pkg::REG_STATUS, d);
    check("late slot clear", d[fdcc_pkg::ST_LATE_IR_BIT], 1'b0);
    while (exp_q.size() > 0)
      pop_chk();
    chk_flags();
    fill_dly <= 10'h0c8;
    drain_dly <= 10'h003;
    repeat (3) push_word(ok);
    wait_bit(fdcc_pkg::ST_LATE_OR_BIT, 1'b1, ok);
    check("late fill", ok, 1'b1);
    pop_chk();
    wr(fdcc_pkg::REG_STATUS, 32'h20);
    repeat (2) pop_chk();
    rd(fdcc_pkg::REG_STATUS, d);
    check("later words", d[fdcc_pkg::ST_LATE_OR_BIT], 1'b0);
    wrap_up();
  end
endmodule : fdcc_ctrl_tb_top
